// ===== logic/soft_reset_and_irq_enable.sv
// Summary of operation
// - Writing one to soft reset bit 3 runs the memory self-test, writing zero stops it.
// - Soft reset bit 2 drives reset to the timestamp, trigger and PTP clock logic.
// - While soft reset bit 0 is set, the enable and status registers return to their defaults and soft reset bits 2 and 3 clear.
// - Strap values latched at power-up are untouched by the global soft reset.
// - The global soft reset bit stays one until software writes it to zero.
// - Enable bit 15 gates the link change interrupt.
// - Enable bit 12 is read-only and shows whether any of the twelve timestamp units has both its enable and its status set.
// - Clearing a timestamp unit enable or its status clears enable bit 12.
// - Enable bit 10 is read-only and shows whether any of the twelve trigger units has both its enable and its status set.
// - Clearing a trigger unit enable or its status clears enable bit 10.
// - Enable bit 3 gates the link-up wake interrupt.
// - Enable bit 2 gates the energy-detect wake interrupt.
// - The interrupt output is high while any status bit and its enable are both set.
// - Link change status is set on any link transition and cleared by writing one.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module soft_reset_and_irq_enable #(
  parameter int unsigned UNITS    = rst_irq_pkg::UNIT_COUNT,
  parameter int unsigned STRAP_W  = rst_irq_pkg::STRAP_W
) (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic                           ce,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [rst_irq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [rst_irq_pkg::DATA_W-1:0] pwdata,
  output logic      [rst_irq_pkg::DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [UNITS-1:0]               timestamp_unit_irq_enables,
  input  wire logic [UNITS-1:0]               timestamp_unit_irq_status,
  input  wire logic [UNITS-1:0]               trigger_unit_irq_enables,
  input  wire logic [UNITS-1:0]               trigger_unit_irq_status,
  input  wire logic                           link_up,
  input  wire logic                           linkup_wake_event,
  input  wire logic                           energy_wake_event,
  input  wire logic [STRAP_W-1:0]             strap_in,
  output logic      [STRAP_W-1:0]             strap_value,
  output logic                                global_soft_reset,
  output logic                                ptp_soft_reset,
  output logic                                bist_run,
  output logic                                irq
);

  import rst_irq_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Unit count must fit the 12-bit per-unit fields
  if (UNITS < 1 || UNITS > 12) begin : g_units_check
    $error("UNITS must lie between 1 and 12");
  end
  // Strap width must be non-zero
  if (STRAP_W < 1) begin : g_strap_check
    $error("STRAP_W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Place a single flag at a bit position of a register word
  function automatic logic [REG_W-1:0] bit_at(input logic val, input int unsigned pos);
    logic [REG_W-1:0] w;
    w      = '0;
    w[pos] = val;
    return w;
  endfunction

  // Zero-extend a register word onto the bus
  function automatic logic [DATA_W-1:0] to_bus(input logic [REG_W-1:0] w);
    return {{(DATA_W-REG_W){1'b0}}, w};
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [REG_W-1:0]   soft_reset_control_r;
  logic [REG_W-1:0]   soft_reset_control_nxt;
  logic [REG_W-1:0]   interrupt_enable_r;
  logic [REG_W-1:0]   interrupt_enable_nxt;
  logic [REG_W-1:0]   irq_status_r;
  logic [REG_W-1:0]   irq_status_nxt;
  logic [DATA_W-1:0]  prdata_r;
  logic [DATA_W-1:0]  prdata_nxt;
  logic               link_up_d_r;
  logic               link_seen_r;
  logic [STRAP_W-1:0] strap_r;
  logic               strap_taken_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic access_ph;
  logic sel_src;
  logic sel_ier;
  logic sel_sts;
  logic sel_clr;
  logic mapped;
  logic wr_src;
  logic wr_ier;
  logic wr_clr;
  logic wr_any;
  logic rd_load;
  logic rd_held_r;

  // Phases and address match
  assign access_ph = psel & penable;
  assign sel_src   = (paddr == ADDR_SOFT_RESET_CONTROL);
  assign sel_ier   = (paddr == ADDR_INTERRUPT_ENABLE);
  assign sel_sts   = (paddr == ADDR_IRQ_STATUS);
  assign sel_clr   = (paddr == ADDR_IRQ_CLEAR);
  assign mapped    = sel_src | sel_ier | sel_sts | sel_clr;

  // Write strobes, taken at the access edge only
  assign wr_any = access_ph & pwrite & ce & mapped;
  assign wr_src = wr_any & sel_src;
  assign wr_ier = wr_any & sel_ier;
  assign wr_clr = wr_any & sel_clr;

  // Zero-wait answer once read data is held, stalls while the clock enable is low
  assign rd_load = psel & ~pwrite & ~pready;
  assign pready  = access_ph & ce & (pwrite | rd_held_r);
  assign pslverr = pready & ~mapped;
  assign prdata  = prdata_r;

  // ----------------------------------------------------------------
  // Soft reset control
  // ----------------------------------------------------------------
  logic             gsr_active;
  logic [REG_W-1:0] src_wr_val;
  logic [REG_W-1:0] src_base;
  logic             src_base_gsr;

  assign gsr_active = soft_reset_control_r[GSR_BIT];
  assign src_wr_val = pwdata[REG_W-1:0] & SRC_RW_MASK;
  assign src_base     = wr_src ? src_wr_val : soft_reset_control_r;
  assign src_base_gsr = src_base[GSR_BIT];
  assign soft_reset_control_nxt = src_base_gsr ? (src_base & SRC_GSR_MASK) : src_base;

  // Control outputs come straight from the register
  // self-test run level
  assign bist_run          = soft_reset_control_r[BIST_BIT];
  assign ptp_soft_reset    = soft_reset_control_r[PTP_RST_BIT] | gsr_active;
  assign global_soft_reset = gsr_active;

  // Soft reset control register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      soft_reset_control_r <= SRC_RESET;
    end else if (ce) begin
      soft_reset_control_r <= soft_reset_control_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Summary enables from the per-unit PTP registers
  // ----------------------------------------------------------------
  logic ts_summary;
  logic ts_rise;
  logic trig_summary;
  logic trig_rise;

  summary_or #(
    .WIDTH (UNITS)
  ) u_ts_summary (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .unit_en (timestamp_unit_irq_enables),
    .unit_st (timestamp_unit_irq_status),
    .summary (ts_summary),
    .rise    (ts_rise)
  );

  summary_or #(
    .WIDTH (UNITS)
  ) u_trig_summary (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .unit_en (trigger_unit_irq_enables),
    .unit_st (trigger_unit_irq_status),
    .summary (trig_summary),
    .rise    (trig_rise)
  );

  // ----------------------------------------------------------------
  // Interrupt enable
  // ----------------------------------------------------------------
  logic [REG_W-1:0] ier_view;
  logic [REG_W-1:0] ier_wr_val;

  // summary bits never stored from writes
  assign ier_wr_val = pwdata[REG_W-1:0] & IER_RW_MASK;
  assign interrupt_enable_nxt = gsr_active ? IER_RESET :
                                wr_ier     ? ier_wr_val : interrupt_enable_r;
  assign ier_view = interrupt_enable_r
                  | bit_at(ts_summary, TS_SUM_BIT)
                  | bit_at(trig_summary, TRIG_SUM_BIT);

  // Interrupt enable register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      interrupt_enable_r <= IER_RESET;
    end else if (ce) begin
      interrupt_enable_r <= interrupt_enable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Event detection and sticky status
  // ----------------------------------------------------------------
  logic             link_change;
  logic [REG_W-1:0] events;
  logic [REG_W-1:0] clr_mask;

  // any link transition after first sample
  assign link_change = link_seen_r & (link_up ^ link_up_d_r);
  // Event vector in status layout
  assign events = bit_at(link_change, LINK_CHANGE_BIT)
                | bit_at(ts_rise, TS_SUM_BIT)
                | bit_at(trig_rise, TRIG_SUM_BIT)
                | bit_at(linkup_wake_event, LINKUP_BIT)
                | bit_at(energy_wake_event, ENERGY_BIT);
  assign clr_mask = wr_clr ? (pwdata[REG_W-1:0] & STATUS_MASK) : '0;
  // Set wins over a clear in the same cycle
  assign irq_status_nxt = gsr_active ? STATUS_RESET : ((irq_status_r & ~clr_mask) | events);

  // Link level history
  always_ff @(posedge clk) begin
    if (!nrst) begin
      link_up_d_r <= 1'b0;
      link_seen_r <= 1'b0;
    end else if (ce) begin
      link_up_d_r <= link_up;
      link_seen_r <= 1'b1;
    end
  end

  // Sticky status register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_status_r <= STATUS_RESET;
    end else if (ce) begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // every status bit gated by its enable
  assign irq = |(irq_status_r & ier_view & STATUS_MASK);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  assign strap_value = strap_r;

  // captured once after reset, soft reset ignored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strap_r       <= '0;
      strap_taken_r <= 1'b0;
    end else if (ce && !strap_taken_r) begin
      strap_r       <= strap_in;
      strap_taken_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read mux, clear register reads zero
  assign prdata_nxt = sel_src ? to_bus(soft_reset_control_r) :
                      sel_ier ? to_bus(ier_view) :
                      sel_sts ? to_bus(irq_status_r) : '0;

  // Loaded at the first enabled edge of a read, stable until pready
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_r <= '0;
    end else if (ce && rd_load) begin
      prdata_r <= prdata_nxt;
    end
  end

  // Marks read data as loaded, so a read set up under a low enable still waits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_held_r <= 1'b0;
    end else if (ce) begin
      rd_held_r <= rd_load;
    end
  end

endmodule

`default_nettype wire

// ===== inc/rst_irq_pkg.sv
`default_nettype none
package rst_irq_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;

  // ----------------------------------------------------------------
  // Register indices and byte addresses (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_SOFT_RESET_CONTROL = 12'h126;
  localparam logic [ADDR_W-1:0] IDX_INTERRUPT_ENABLE   = 12'h190;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET_CONTROL = 12'h498;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_ENABLE   = 12'h640;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS         = 12'h700;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR          = 12'h704;

  // ----------------------------------------------------------------
  // Soft reset control fields
  // ----------------------------------------------------------------
  localparam int unsigned GSR_BIT     = 0;
  localparam int unsigned PTP_RST_BIT = 2;
  localparam int unsigned BIST_BIT    = 3;
  localparam logic [REG_W-1:0] SRC_RW_MASK  = 16'h000D;
  localparam logic [REG_W-1:0] SRC_GSR_MASK = 16'h0001;
  localparam logic [REG_W-1:0] SRC_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // Interrupt enable / status layout
  // ----------------------------------------------------------------
  localparam int unsigned LINK_CHANGE_BIT = 15;
  localparam int unsigned TS_SUM_BIT      = 12;
  localparam int unsigned TRIG_SUM_BIT    = 10;
  localparam int unsigned LINKUP_BIT      = 3;
  localparam int unsigned ENERGY_BIT      = 2;
  localparam logic [REG_W-1:0] IER_RW_MASK  = 16'h800C;
  localparam logic [REG_W-1:0] STATUS_MASK  = 16'h940C;
  localparam logic [REG_W-1:0] IER_RESET    = 16'h0000;
  localparam logic [REG_W-1:0] STATUS_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Per-unit count and strap width
  // ----------------------------------------------------------------
  localparam int unsigned UNIT_COUNT = 12;
  localparam int unsigned STRAP_W    = 8;

  // ----------------------------------------------------------------
  // Timing: host wait after global soft reset
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 25000000;
  localparam int unsigned SOFT_RESET_WAIT_MS = 10;
  localparam int unsigned SOFT_RESET_WAIT_CYC = (CLK_HZ / 1000) * SOFT_RESET_WAIT_MS;

endpackage

`default_nettype wire

// ===== logic/summary_or.sv
`timescale 1ns/10ps
`default_nettype none

module summary_or #(
  parameter int unsigned WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] unit_en,
  input  wire logic [WIDTH-1:0] unit_st,
  output logic                  summary,
  output logic                  rise
);

  logic prev_r;
  logic pend;

  // ----------------------------------------------------------------
  // Summary and its rising edge
  // ----------------------------------------------------------------
  // Enabled unit with pending status
  assign pend    = |(unit_en & unit_st);
  assign summary = pend;
  assign rise    = pend & ~prev_r;

  // Previous summary value
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_r <= 1'b0;
    end else if (ce) begin
      prev_r <= pend;
    end
  end

endmodule

`default_nettype wire

// ===== sim/rst_irq_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rst_irq_chk #(
  parameter int unsigned UNITS   = 12,
  parameter int unsigned STRAP_W = 8
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               ce,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic [UNITS-1:0]   timestamp_unit_irq_enables,
  input wire logic [UNITS-1:0]   timestamp_unit_irq_status,
  input wire logic [UNITS-1:0]   trigger_unit_irq_enables,
  input wire logic [UNITS-1:0]   trigger_unit_irq_status,
  input wire logic [STRAP_W-1:0] strap_value,
  input wire logic               global_soft_reset,
  input wire logic               ptp_soft_reset,
  input wire logic               bist_run,
  input wire logic               irq
);
  import rst_irq_pkg::*;
  logic        wr_ctrl;
  logic [31:0] wd_r;
  // Control write in access phase
  assign wr_ctrl = psel && penable && ce && pwrite && (paddr == ADDR_SOFT_RESET_CONTROL);
  // Write data of the last edge
  always_ff @(posedge clk) wd_r <= pwdata;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  // Enable read setup, soft reset idle
  sequence s_rd_ier;
    psel && !penable && ce && !pwrite && paddr == ADDR_INTERRUPT_ENABLE
      && !global_soft_reset && !$past(global_soft_reset);
  endsequence
  sequence s_gsr_on;
    global_soft_reset [*2];
  endsequence
  property p_bist;
    wr_ctrl |=> bist_run == (wd_r[BIST_BIT] && !wd_r[GSR_BIT]);
  endproperty
  a_bist: assert property (p_bist) else $error("self-test run wrong");
  property p_ptp;
    wr_ctrl |=> ptp_soft_reset == (wd_r[PTP_RST_BIT] || wd_r[GSR_BIT]);
  endproperty
  a_ptp: assert property (p_ptp) else $error("time reset wrong");
  property p_ptp_hold;
    ptp_soft_reset && !wr_ctrl |=> ptp_soft_reset;
  endproperty
  a_ptp_hold: assert property (p_ptp_hold) else $error("time reset dropped");
  property p_gsr_keep;
    global_soft_reset && !wr_ctrl |=> global_soft_reset;
  endproperty
  a_gsr_keep: assert property (p_gsr_keep) else $error("soft reset cleared itself");
  property p_gsr_quiet;
    s_gsr_on |-> !irq && !bist_run;
  endproperty
  a_gsr_quiet: assert property (p_gsr_quiet) else $error("state kept in soft reset");
  property p_strap;
    global_soft_reset |=> $stable(strap_value);
  endproperty
  a_strap: assert property (p_strap) else $error("strap copy changed");
  property p_ts;
    s_rd_ier ##0 ($stable(timestamp_unit_irq_enables) && $stable(timestamp_unit_irq_status))
      |=> prdata[TS_SUM_BIT] == |($past(timestamp_unit_irq_enables) & $past(timestamp_unit_irq_status));
  endproperty
  a_ts: assert property (p_ts) else $error("timestamp summary wrong");
  property p_trig;
    s_rd_ier ##0 ($stable(trigger_unit_irq_enables) && $stable(trigger_unit_irq_status))
      |=> prdata[TRIG_SUM_BIT] == |($past(trigger_unit_irq_enables) & $past(trigger_unit_irq_status));
  endproperty
  a_trig: assert property (p_trig) else $error("trigger summary wrong");
endmodule
`default_nettype wire

// ===== sim/apb_host.sv
`timescale 1ns/10ps
`default_nettype none
module apb_host #(
  parameter int unsigned HOLD_CYC = rst_irq_pkg::SOFT_RESET_WAIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  import rst_irq_pkg::*;
  logic [31:0] rq;
  logic        re;
  // Idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
  end
  // One transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic wr_ier(input logic [31:0] d);
    xfer(1'b1, ADDR_INTERRUPT_ENABLE, d & 32'hFFFF_EBFF, rq, re);
  endtask
  task automatic hold_wait();
    repeat (HOLD_CYC) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module tb;
  import rst_irq_pkg::*;
  logic        clk, nrst, ce, psel, penable, pwrite, pready, pslverr, link_up, er;
  logic        linkup_wake_event, energy_wake_event, global_soft_reset, ptp_soft_reset;
  logic        bist_run, irq;
  logic [11:0] paddr, ts_en, ts_st, tr_en, tr_st;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  strap_in, strap_value;
  logic [15:0] m_ier;
  logic [15:0] cv [4] = '{16'hFFFA, 16'h000C, 16'h0004, 16'h0000};
  int          bits [3] = '{15, 3, 2};
  int          n_fail, cmp_count;
  soft_reset_and_irq_enable u_soft_reset_and_irq_enable (.clk(clk), .nrst(nrst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timestamp_unit_irq_enables(ts_en),
    .timestamp_unit_irq_status(ts_st), .trigger_unit_irq_enables(tr_en),
    .trigger_unit_irq_status(tr_st), .link_up(link_up), .linkup_wake_event(linkup_wake_event),
    .energy_wake_event(energy_wake_event), .strap_in(strap_in), .strap_value(strap_value),
    .global_soft_reset(global_soft_reset), .ptp_soft_reset(ptp_soft_reset),
    .bist_run(bist_run), .irq(irq));
  // Shortened soft reset hold, the full wait would outrun the cycle budget
  apb_host #(.HOLD_CYC(50)) u_host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Expected enable read from the model
  function automatic logic [15:0] exp_ier();
    return m_ier | {3'b000, |(ts_en & ts_st), 1'b0, |(tr_en & tr_st), 10'h000};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, er);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input string nm);
    u_host.xfer(1'b0, a, 32'h0000_0000, q, er);
    `CHK(nm, {16'h0000, e}, q)
  endtask
  // Raise one interrupt source
  task automatic fire(input int b);
    @(posedge clk);
    if (b == 15) link_up <= ~link_up;
    linkup_wake_event <= (b == 3);
    energy_wake_event <= (b == 2);
    @(posedge clk);
    {linkup_wake_event, energy_wake_event} <= 2'b00;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("unexpected timeout: expected done seen hang");
    end_sim();
  end
  initial begin
    {nrst, ce, link_up, linkup_wake_event, energy_wake_event} = 5'b01000;
    {ts_en, ts_st, tr_en, tr_st} = 48'h0;
    strap_in = 8'hA5;
    m_ier = 16'h0000;
    void'($urandom(4415));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_SOFT_RESET_CONTROL, SRC_RESET, "ctrl");
    rd(ADDR_INTERRUPT_ENABLE, IER_RESET, "ier");
    rd(ADDR_IRQ_STATUS, STATUS_RESET, "status");
    u_host.xfer(1'b0, 12'h004, 32'h0000_0000, q, er);
    `CHK("unmapped error", 1'b1, er)
    $display("test defaults done");
    foreach (cv[i]) begin
      wr(ADDR_SOFT_RESET_CONTROL, {16'h0000, cv[i]});
      `CHK("bist", cv[i][3], bist_run)
      `CHK("ptp reset", cv[i][2], ptp_soft_reset)
      rd(ADDR_SOFT_RESET_CONTROL, cv[i] & SRC_RW_MASK, "ctrl");
    end
    $display("test control done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {ts_en, tr_en} <= 24'($urandom);
      {ts_st, tr_st} <= 24'($urandom) & 24'($urandom) & 24'($urandom);
      q = $urandom;
      m_ier = q[15:0] & IER_RW_MASK;
      u_host.wr_ier(q);
      rd(ADDR_INTERRUPT_ENABLE, exp_ier(), "ier");
    end
    @(posedge clk);
    {ts_en, ts_st, tr_en, tr_st} <= 48'h0;
    m_ier = 16'h0000;
    u_host.wr_ier(32'h0);
    wr(ADDR_IRQ_CLEAR, 32'h0000_FFFF);
    $display("test enable done");
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      if (j == 0) {ts_en, ts_st} <= 24'h010_010;
      else {tr_en, tr_st} <= 24'h800_800;
      repeat (3) @(posedge clk);
      #1;
      `CHK("summary irq", 1'b1, irq)
      rd(ADDR_INTERRUPT_ENABLE, exp_ier(), "ier sum");
      @(posedge clk);
      if (j == 0) ts_en <= 12'h000;
      else tr_st <= 12'h000;
      repeat (2) @(posedge clk);
      rd(ADDR_INTERRUPT_ENABLE, exp_ier(), "ier sum off");
      #1;
      `CHK("summary irq off", 1'b0, irq)
      wr(ADDR_IRQ_CLEAR, 32'h0000_FFFF);
    end
    @(posedge clk);
    {ts_st, tr_en} <= 24'h0;
    $display("test summary done");
    foreach (bits[k]) begin
      u_host.wr_ier(32'h1 << bits[k]);
      fire(bits[k]);
      `CHK("irq on", 1'b1, irq)
      u_host.wr_ier(32'h0);
      #1;
      `CHK("irq masked", 1'b0, irq)
      rd(ADDR_IRQ_STATUS, 16'h1 << bits[k], "status");
      wr(ADDR_IRQ_CLEAR, 32'h1 << bits[k]);
      rd(ADDR_IRQ_STATUS, 16'h0000, "status cleared");
    end
    $display("test interrupts done");
    u_host.wr_ier(32'h0000_800C);
    fire(15);
    strap_in <= 8'h5A;
    wr(ADDR_SOFT_RESET_CONTROL, 32'h0000_0005);
    `CHK("gsr", 1'b1, global_soft_reset)
    `CHK("gsr ptp", 1'b1, ptp_soft_reset)
    rd(ADDR_SOFT_RESET_CONTROL, 16'h0001, "ctrl gsr");
    rd(ADDR_IRQ_STATUS, 16'h0000, "status gsr");
    u_host.wr_ier(32'h0000_800C);
    rd(ADDR_INTERRUPT_ENABLE, 16'h0000, "ier gsr");
    #1;
    `CHK("irq gsr", 1'b0, irq)
    u_host.hold_wait();
    `CHK("gsr held", 1'b1, global_soft_reset)
    `CHK("strap", 8'hA5, strap_value)
    wr(ADDR_SOFT_RESET_CONTROL, 32'h0000_0000);
    `CHK("ptp released", 1'b0, ptp_soft_reset)
    m_ier = 16'h800C;
    u_host.wr_ier(32'h0000_800C);
    rd(ADDR_INTERRUPT_ENABLE, exp_ier(), "ier after");
    $display("test soft reset done");
    @(posedge clk);
    ce <= 1'b0;
    linkup_wake_event <= 1'b1;
    fork
      rd(ADDR_IRQ_STATUS, 16'h0000, "status stalled");
      begin
        repeat (4) @(posedge clk);
        {ce, linkup_wake_event} <= 2'b10;
      end
    join
    #1;
    `CHK("irq frozen", 1'b0, irq)
    $display("test clock enable done");
    end_sim();
  end
endmodule
bind soft_reset_and_irq_enable rst_irq_chk #(.UNITS(UNITS), .STRAP_W(STRAP_W)) u_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .timestamp_unit_irq_enables(timestamp_unit_irq_enables),
  .timestamp_unit_irq_status(timestamp_unit_irq_status),
  .trigger_unit_irq_enables(trigger_unit_irq_enables),
  .trigger_unit_irq_status(trigger_unit_irq_status), .strap_value(strap_value),
  .global_soft_reset(global_soft_reset), .ptp_soft_reset(ptp_soft_reset),
  .bist_run(bist_run), .irq(irq));
`default_nettype wire
